// ### rtl/cid_pkg.sv
// Constants and types shared by the cape identification reader
package cid_pkg;
  // ---------------------------------------------------------------
  // Bus addressing window and link rate
  // ---------------------------------------------------------------
  localparam logic [6:0] ID_ADDR_BASE = 7'h54;
  localparam logic [6:0] ID_ADDR_LAST = 7'h57;
  localparam int         I2C_STD_KHZ  = 100;
  localparam int         I2C_FAST_KHZ = 400;
  localparam int         I2C_FPLUS_KHZ = 1000;
  localparam int         I2C_KHZ      = I2C_FAST_KHZ;
  localparam int         LINK_CLK_KHZ = 166667;
  // Quarter of an SCL period in link cycles, rounded up (never too fast)
  localparam int QTR_CYC = (LINK_CLK_KHZ + 4 * I2C_KHZ - 1) / (4 * I2C_KHZ);

  // ---------------------------------------------------------------
  // Image layout (byte offsets, sizes, marker values)
  // ---------------------------------------------------------------
  localparam logic [7:0]  OFS_HEADER    = 8'h00;
  localparam logic [7:0]  OFS_REV       = 8'h04;
  localparam logic [7:0]  OFS_NAME      = 8'h06;
  localparam logic [7:0]  OFS_VERSION   = 8'h26;
  localparam logic [7:0]  OFS_MAKER     = 8'h2a;
  localparam logic [7:0]  OFS_PART      = 8'h3a;
  localparam logic [7:0]  OFS_PIN_COUNT = 8'h4a;
  localparam logic [7:0]  OFS_SERIAL    = 8'h4c;
  localparam logic [7:0]  OFS_PINS      = 8'h58;
  localparam logic [7:0]  OFS_CUR_3V3   = 8'hec;
  localparam logic [7:0]  OFS_CUR_5V    = 8'hee;
  localparam logic [7:0]  OFS_CUR_SYS5V = 8'hf0;
  localparam logic [7:0]  OFS_DC_SUPPLY = 8'hf2;
  localparam logic [7:0]  OFS_FREE      = 8'hf4;
  localparam logic [15:0] FREE_LEN      = 16'h7f1f;
  localparam int          PIN_COUNT     = 74;
  localparam logic [31:0] HDR_MARKER    = 32'haa5533ee;
  localparam logic [15:0] REV_A1        = 16'h4131;

  // ---------------------------------------------------------------
  // Pin configuration word fields
  // ---------------------------------------------------------------
  localparam int PCW_USED_BIT  = 15;
  localparam int PCW_EDGE_BIT  = 6;
  localparam int PCW_RX_BIT    = 5;
  localparam int PCW_BDIR_BIT  = 4;
  localparam int PCW_BDIS_BIT  = 3;
  localparam int PCW_MUX_MSB   = 2;
  localparam int AIN_FIRST     = 67;
  localparam int AIN_COUNT     = 7;

  // Byte-level operations handed to the link engine
  typedef enum logic [2:0] {
    OP_START, OP_WRITE, OP_READ_ACK, OP_READ_NACK, OP_STOP
  } cid_op_type;
endpackage

// ### rtl/cid_link_if.sv
// Handshake carrier between the reader sequencer and the link engine
`timescale 1ns/1ps
interface cid_link_if;
  import cid_pkg::*;
  logic       req_tgl;
  cid_op_type op;
  logic [7:0] wbyte;
  logic       done_tgl;
  logic [7:0] rbyte;
  logic       nack;
  modport ctrl (output req_tgl, op, wbyte, input done_tgl, rbyte, nack);
  modport eng  (input req_tgl, op, wbyte, output done_tgl, rbyte, nack);
endinterface

// ### rtl/cid_i2c_engine.sv
// Byte-level open-drain bus engine on the link clock
`timescale 1ns/1ps
module cid_i2c_engine
  import cid_pkg::*;
#(
  parameter int QTR = QTR_CYC
) (
  input  wire logic clk_link,
  input  wire logic arst_n,
  cid_link_if.eng   lk,
  input  wire logic scl_i,
  output logic      scl_oe,
  input  wire logic sda_i,
  output logic      sda_oe
);
  typedef enum logic {E_IDLE, E_RUN} cid_eng_st_type;
  typedef struct packed {
    cid_eng_st_type st;
    cid_op_type     op;
    logic [1:0]     q;
    logic [11:0]    tick;
    logic [3:0]     bitn;
    logic [8:0]     sh;
    logic           scl_oe;
    logic           sda_oe;
    logic [2:0]     req_s;
    logic [1:0]     sda_s;
    logic [1:0]     scl_s;
    logic           done_tgl;
    logic [7:0]     rbyte;
    logic           nack;
  } cid_eng_type;

  cid_eng_type st_r;
  cid_eng_type st_nxt;

  // ---------------------------------------------------------------
  // Quarter-period sequencer; one op is four quarters per bit
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.req_s = {st_r.req_s[1:0], lk.req_tgl};
    st_nxt.sda_s = {st_r.sda_s[0], sda_i};
    st_nxt.scl_s = {st_r.scl_s[0], scl_i};
    case (st_r.st)
      E_IDLE: begin
        if (st_r.req_s[2] != st_r.req_s[1]) begin
          st_nxt.st   = E_RUN;
          st_nxt.op   = lk.op;
          st_nxt.q    = 2'h0;
          st_nxt.tick = 12'h000;
          st_nxt.bitn = 4'h0;
          // Ack slot is the ninth bit: released on writes and NACK reads, driven on ACK reads
          case (lk.op)
            OP_WRITE:    st_nxt.sh = {lk.wbyte, 1'b1};
            OP_READ_ACK: st_nxt.sh = 9'h1fe;
            default:     st_nxt.sh = 9'h1ff;
          endcase
          if (lk.op == OP_START) begin
            st_nxt.sda_oe = 1'b0;
          end else if (lk.op == OP_STOP) begin
            st_nxt.sda_oe = 1'b1;
          end else begin
            st_nxt.sda_oe = ~st_nxt.sh[8];
          end
        end
      end
      E_RUN: begin
        // Hold the high phase while a slave stretches the clock
        if (st_r.q == 2'h2 && !st_r.scl_s[1]) begin
          st_nxt.tick = 12'h000;
        end else if (st_r.tick != 12'(QTR - 1)) begin
          st_nxt.tick = st_r.tick + 12'h001;
        end else begin
          st_nxt.tick = 12'h000;
          st_nxt.q    = st_r.q + 2'h1;
          case (st_r.q)
            2'h0: st_nxt.scl_oe = 1'b0;
            2'h1: begin
              if (st_r.op == OP_START) begin
                st_nxt.sda_oe = 1'b1;
              end
            end
            2'h2: begin
              if (st_r.op == OP_STOP) begin
                st_nxt.sda_oe = 1'b0;
              end else begin
                st_nxt.scl_oe = 1'b1;
              end
              if (st_r.op != OP_START && st_r.op != OP_STOP) begin
                st_nxt.sh = {st_r.sh[7:0], st_r.sda_s[1]};
              end
            end
            default: begin
              if (st_r.op == OP_START || st_r.op == OP_STOP || st_r.bitn == 4'h8) begin
                st_nxt.st       = E_IDLE;
                st_nxt.done_tgl = ~st_r.done_tgl;
                st_nxt.rbyte    = st_r.sh[8:1];
                st_nxt.nack     = st_r.sh[0];
              end else begin
                st_nxt.bitn   = st_r.bitn + 4'h1;
                st_nxt.sda_oe = ~st_r.sh[8];
              end
            end
          endcase
        end
      end
      default: st_nxt.st = E_IDLE;
    endcase
  end

  // State register; bus released during reset
  always_ff @(posedge clk_link or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lk.done_tgl = st_r.done_tgl;
  assign lk.rbyte    = st_r.rbyte;
  assign lk.nack     = st_r.nack;
  assign scl_oe      = st_r.scl_oe;
  assign sda_oe      = st_r.sda_oe;
endmodule

// ### rtl/cid_reader.sv
// Expansion board identification reader: fetch and decode the ID image
//
// Summary of operation
// - Probe only bus addresses 0x54 to 0x57
// - Send two address bytes, one byte each
// - Sixteen-bit fields arrive most significant first
// - Image starts with marker AA 55 33 EE
// - Bytes 4 and 5 hold revision A1
// - Name, version, maker, part at fixed offsets
// - Offset 74 holds used header pin count
// - Twelve-character serial number from offset 76
// - Seventy-four pin words from offset 88
// - Three rail current limits at 236-240
// - Offset 242 says board feeds 5V rail
// - Free area from 244 is never decoded
// - Pin word bit 15 marks pin used
// - Pin word bits 14 to 7 ignored
// - Bit 6 selects fast or slow edges
// - Bit 5 enables the input receiver
// - Bit 4 bias direction, bit 3 bias disable
// - Bits 2 to 0 select mux mode
// - Analog pins keep only the used bit
// - Bus runs at standard, fast or fast-plus
`timescale 1ns/1ps
module cid_reader
  import cid_pkg::*;
#(
  parameter int QTR       = QTR_CYC,
  parameter int AIN_LO    = AIN_FIRST,
  parameter int AIN_NUM   = AIN_COUNT
) (
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic         clk_link,
  input  wire logic         start_req,
  input  wire logic [1:0]   board_slot,
  input  wire logic [6:0]   pin_sel,
  input  wire logic         scl_i,
  output logic              scl_oe,
  input  wire logic         sda_i,
  output logic              sda_oe,
  output logic              busy,
  output logic              done,
  output logic              board_present,
  output logic              no_ack,
  output logic              bad_header,
  output logic              format_rev_ok,
  output logic [15:0]       format_rev,
  output logic [31:0]       hw_version,
  output logic [127:0]      maker_name,
  output logic [127:0]      part_number,
  output logic [15:0]       pin_count,
  output logic [95:0]       serial_number,
  output logic [15:0]       cur_board_3v3,
  output logic [15:0]       cur_board_5v,
  output logic [15:0]       cur_system_5v,
  output logic [15:0]       supplies_board_5v,
  output logic              pin_used,
  output logic              edge_rate_select,
  output logic              rx_enable,
  output logic              bias_direction_select,
  output logic              bias_disable,
  output logic [2:0]        mux_mode
);
  // ---------------------------------------------------------------
  // Sequencer state: each state but M_IDLE names the op that is in flight
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    M_IDLE, M_START, M_DEVW, M_AHI, M_ALO, M_RSTART, M_DEVR, M_READ, M_STOP
  } cid_main_st_type;

  typedef struct packed {
    cid_main_st_type           st;
    logic                      req_tgl;
    cid_op_type                op;
    logic [7:0]                wbyte;
    logic [2:0]                ack_s;
    logic [6:0]                dev;
    logic [7:0]                ofs;
    logic [7:0]                byte_hi;
    logic                      busy;
    logic                      done;
    logic                      present;
    logic                      no_ack;
    logic                      bad_hdr;
    logic                      rev_ok;
    logic [15:0]               rev;
    logic [31:0]               version;
    logic [127:0]              maker;
    logic [127:0]              part;
    logic [15:0]               pin_cnt;
    logic [95:0]               serial;
    logic [15:0]               cur_3v3;
    logic [15:0]               cur_5v;
    logic [15:0]               cur_sys5v;
    logic [15:0]               dc_sup;
    logic [PIN_COUNT-1:0][15:0] pins;
    logic                      p_used;
    logic                      p_edge;
    logic                      p_rx;
    logic                      p_bdir;
    logic                      p_bdis;
    logic [2:0]                p_mux;
  } cid_main_type;

  cid_main_type st_r;
  cid_main_type st_nxt;

  cid_link_if lk ();

  // Link engine lives in the link clock domain
  cid_i2c_engine #(
    .QTR      (QTR)
  ) u_engine (
    .clk_link (clk_link),
    .arst_n   (arst_n),
    .lk       (lk.eng),
    .scl_i    (scl_i),
    .scl_oe   (scl_oe),
    .sda_i    (sda_i),
    .sda_oe   (sda_oe)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Hand one op to the engine; op and byte hold until the next toggle
  function automatic cid_main_type issue(input cid_main_type s,
                                         input cid_op_type   o,
                                         input logic [7:0]   b);
    cid_main_type t;
    t         = s;
    t.req_tgl = ~s.req_tgl;
    t.op      = o;
    t.wbyte   = b;
    return t;
  endfunction

  // Join two bytes, first received on top
  function automatic logic [15:0] be16(input logic [7:0] hi,
                                       input logic [7:0] lo);
    return {hi, lo};
  endfunction

  // Expected marker byte for header position 0..3
  function automatic logic [7:0] hdr_byte(input logic [1:0] i);
    return HDR_MARKER[8'(31 - 8 * int'(i)) -: 8];
  endfunction

  // True when offset lies within [base, base+len)
  function automatic logic in_field(input logic [7:0] a,
                                    input logic [7:0] base,
                                    input int         len);
    return (a >= base) && (9'(a) < 9'(int'(base) + len));
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic        done_ev;
    logic [7:0]  b;
    logic [15:0] w;
    logic [7:0]  pofs;
    logic [6:0]  pidx;
    logic [15:0] sel_w;
    logic        sel_ain;
    done_ev = 1'b0;
    b       = 8'h00;
    w       = 16'h0000;
    pofs    = 8'h00;
    pidx    = 7'h00;
    sel_w   = 16'h0000;
    sel_ain = 1'b0;

    st_nxt       = st_r;
    st_nxt.done  = 1'b0;
    // Completion toggle crosses back through two flops before use
    st_nxt.ack_s = {st_r.ack_s[1:0], lk.done_tgl};
    done_ev      = st_r.ack_s[2] != st_r.ack_s[1];
    b            = lk.rbyte;
    w            = be16(st_r.byte_hi, b);

    case (st_r.st)
      M_IDLE: begin
        if (start_req) begin
          st_nxt         = issue(st_nxt, OP_START, 8'h00);
          st_nxt.st      = M_START;
          st_nxt.busy    = 1'b1;
          st_nxt.present = 1'b0;
          st_nxt.no_ack  = 1'b0;
          st_nxt.bad_hdr = 1'b0;
          st_nxt.rev_ok  = 1'b0;
          st_nxt.ofs     = OFS_HEADER;
          st_nxt.pins    = '0;
          // Strap window: base address plus the selected slot
          st_nxt.dev     = ID_ADDR_BASE | {5'h00, board_slot};
        end
      end
      M_START: begin
        if (done_ev) begin
          st_nxt    = issue(st_nxt, OP_WRITE, {st_r.dev, 1'b0});
          st_nxt.st = M_DEVW;
        end
      end
      M_DEVW, M_AHI, M_ALO: begin
        if (done_ev && lk.nack) begin
          st_nxt.no_ack = 1'b1;
          st_nxt        = issue(st_nxt, OP_STOP, 8'h00);
          st_nxt.st     = M_STOP;
        end else if (done_ev && st_r.st == M_DEVW) begin
          // Word address high byte, then low byte
          st_nxt    = issue(st_nxt, OP_WRITE, 8'h00);
          st_nxt.st = M_AHI;
        end else if (done_ev && st_r.st == M_AHI) begin
          st_nxt    = issue(st_nxt, OP_WRITE, OFS_HEADER);
          st_nxt.st = M_ALO;
        end else if (done_ev) begin
          st_nxt    = issue(st_nxt, OP_START, 8'h00);
          st_nxt.st = M_RSTART;
        end
      end
      M_RSTART: begin
        if (done_ev) begin
          st_nxt    = issue(st_nxt, OP_WRITE, {st_r.dev, 1'b1});
          st_nxt.st = M_DEVR;
        end
      end
      M_DEVR: begin
        if (done_ev && lk.nack) begin
          st_nxt.no_ack = 1'b1;
          st_nxt        = issue(st_nxt, OP_STOP, 8'h00);
          st_nxt.st     = M_STOP;
        end else if (done_ev) begin
          st_nxt    = issue(st_nxt, OP_READ_ACK, 8'h00);
          st_nxt.st = M_READ;
        end
      end
      M_READ: begin
        if (done_ev) begin
          // Each address gives one byte; keep even byte as upper half
          if (!st_r.ofs[0]) begin
            st_nxt.byte_hi = b;
          end
          if (st_r.ofs < OFS_REV && b != hdr_byte(st_r.ofs[1:0])) begin
            st_nxt.bad_hdr = 1'b1;
          end
          if (st_r.ofs == OFS_REV + 8'h01) begin
            st_nxt.rev = w;
          end
          // Board name carries no decoded meaning and is skipped
          if (in_field(st_r.ofs, OFS_VERSION, 4)) begin
            st_nxt.version = {st_r.version[23:0], b};
          end
          if (in_field(st_r.ofs, OFS_MAKER, 16)) begin
            st_nxt.maker = {st_r.maker[119:0], b};
          end
          if (in_field(st_r.ofs, OFS_PART, 16)) begin
            st_nxt.part = {st_r.part[119:0], b};
          end
          if (st_r.ofs == OFS_PIN_COUNT + 8'h01) begin
            st_nxt.pin_cnt = w;
          end
          if (in_field(st_r.ofs, OFS_SERIAL, 12)) begin
            st_nxt.serial = {st_r.serial[87:0], b};
          end
          // One word per pin, stored once its low byte lands
          if (in_field(st_r.ofs, OFS_PINS, 2 * PIN_COUNT) && st_r.ofs[0]) begin
            pofs               = st_r.ofs - OFS_PINS;
            pidx               = pofs[7:1];
            st_nxt.pins[pidx]  = w;
          end
          if (st_r.ofs == OFS_CUR_3V3 + 8'h01) begin
            st_nxt.cur_3v3 = w;
          end
          if (st_r.ofs == OFS_CUR_5V + 8'h01) begin
            st_nxt.cur_5v = w;
          end
          if (st_r.ofs == OFS_CUR_SYS5V + 8'h01) begin
            st_nxt.cur_sys5v = w;
          end
          if (st_r.ofs == OFS_DC_SUPPLY + 8'h01) begin
            st_nxt.dc_sup = w;
          end
          // Stop short of the free area: it is user data, not ID content
          if (st_r.ofs == OFS_FREE - 8'h01) begin
            st_nxt    = issue(st_nxt, OP_STOP, 8'h00);
            st_nxt.st = M_STOP;
          end else begin
            st_nxt.ofs = st_r.ofs + 8'h01;
            // Last byte gets a not-acknowledge so the memory frees the bus
            if (st_r.ofs == OFS_FREE - 8'h02) begin
              st_nxt = issue(st_nxt, OP_READ_NACK, 8'h00);
            end else begin
              st_nxt = issue(st_nxt, OP_READ_ACK, 8'h00);
            end
          end
        end
      end
      M_STOP: begin
        if (done_ev) begin
          st_nxt.st      = M_IDLE;
          st_nxt.busy    = 1'b0;
          st_nxt.done    = 1'b1;
          st_nxt.present = !st_r.no_ack && !st_r.bad_hdr;
          st_nxt.rev_ok  = !st_r.no_ack && st_r.rev == REV_A1;
        end
      end
      default: st_nxt.st = M_IDLE;
    endcase

    // Pin lookup: decode the selected word into its fields
    if (int'(pin_sel) < PIN_COUNT) begin
      sel_w = st_r.pins[pin_sel];
    end
    sel_ain = int'(pin_sel) >= AIN_LO && int'(pin_sel) < AIN_LO + AIN_NUM;
    st_nxt.p_used = sel_w[PCW_USED_BIT];
    // Bits 14..7 are never looked at; analog pins keep only the used flag
    if (sel_ain) begin
      st_nxt.p_edge = 1'b0;
      st_nxt.p_rx   = 1'b0;
      st_nxt.p_bdir = 1'b0;
      st_nxt.p_bdis = 1'b0;
      st_nxt.p_mux  = 3'h0;
    end else begin
      st_nxt.p_edge = sel_w[PCW_EDGE_BIT];
      st_nxt.p_rx   = sel_w[PCW_RX_BIT];
      st_nxt.p_bdir = sel_w[PCW_BDIR_BIT];
      st_nxt.p_bdis = sel_w[PCW_BDIS_BIT];
      st_nxt.p_mux  = sel_w[PCW_MUX_MSB:0];
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Request side of the crossing; data stable before the toggle is seen
  assign lk.req_tgl = st_r.req_tgl;
  assign lk.op      = st_r.op;
  assign lk.wbyte   = st_r.wbyte;

  // Outputs straight from the state register
  assign busy                  = st_r.busy;
  assign done                  = st_r.done;
  assign board_present         = st_r.present;
  assign no_ack                = st_r.no_ack;
  assign bad_header            = st_r.bad_hdr;
  assign format_rev_ok         = st_r.rev_ok;
  assign format_rev            = st_r.rev;
  assign hw_version            = st_r.version;
  assign maker_name            = st_r.maker;
  assign part_number           = st_r.part;
  assign pin_count             = st_r.pin_cnt;
  assign serial_number         = st_r.serial;
  assign cur_board_3v3         = st_r.cur_3v3;
  assign cur_board_5v          = st_r.cur_5v;
  assign cur_system_5v         = st_r.cur_sys5v;
  assign supplies_board_5v     = st_r.dc_sup;
  assign pin_used              = st_r.p_used;
  assign edge_rate_select      = st_r.p_edge;
  assign rx_enable             = st_r.p_rx;
  assign bias_direction_select = st_r.p_bdir;
  assign bias_disable          = st_r.p_bdis;
  assign mux_mode              = st_r.p_mux;
endmodule

// ### test/cid_reader_asserts.sv
// Port-level checks for the identification reader
`timescale 1ns/1ps
module cid_reader_asserts
  import cid_pkg::*;
#(parameter int AIN_LO = AIN_FIRST) (
  input wire logic        clk_sys,
  input wire logic        arst_n,
  input wire logic [6:0]  pin_sel,
  input wire logic        scl_oe,
  input wire logic        sda_oe,
  input wire logic        busy,
  input wire logic        done,
  input wire logic        board_present,
  input wire logic        no_ack,
  input wire logic        bad_header,
  input wire logic        format_rev_ok,
  input wire logic [15:0] format_rev,
  input wire logic        pin_used,
  input wire logic        rx_enable,
  input wire logic [2:0]  mux_mode
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Completion closes a busy scan and lasts a single cycle
  a_done_pulse: assert property (done |-> $past(busy) && !busy ##1 !done)
    else $error("done pulse wrong");
  a_present_excl: assert property (board_present |-> !no_ack && !bad_header)
    else $error("present with fault");
  a_flags_clear: assert property ($rose(busy) |-> !(board_present | no_ack | bad_header))
    else $error("flags not cleared");
  // Verdict flags only move while busy or at done, so software reads a stable answer
  a_flags_hold: assert property (!busy && !done |-> $stable({board_present, no_ack}))
    else $error("flags moved idle");
  a_rev_match: assert property (format_rev_ok |-> format_rev == REV_A1)
    else $error("revision flag wrong");
  a_analog_mask: assert property (pin_sel >= 7'(AIN_LO) |=> !rx_enable && mux_mode == 3'h0)
    else $error("analog pin fields");
  a_pin_range: assert property (pin_sel > 7'h49 |=> !pin_used)
    else $error("pin beyond range");
  a_bus_idle: assert property (!busy && !done |-> !scl_oe && !sda_oe)
    else $error("bus driven idle");
  c_present: cover property (done && board_present);
  c_no_ack: cover property (done && no_ack);
  c_bad_header: cover property (done && bad_header);
endmodule
bind cid_reader cid_reader_asserts #(.AIN_LO(AIN_LO)) cid_reader_asserts_i (.*);

// ### test/cid_eeprom_model.sv
// Behavioural identification memory answering on the open-drain bus
`timescale 1ns/1ps
module cid_eeprom_model #(
  parameter logic [6:0] ADDR = 7'h56
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic slow,
  output logic      scl_oe = 1'b0,
  output logic      sda_oe = 1'b0
);
  logic [7:0]  mem [0:255];
  logic [15:0] ptr;
  logic [7:0]  b;
  logic        m;
  bit          armed;
  // Start arms a transfer, stop drops it; our own SDA moves only while SCL is low
  always @(sda) if (scl === 1'b1) begin
    armed = !sda;
    sda_oe = 1'b0;
    disable xfer;
  end
  task automatic rx;
    repeat (8) @(posedge scl) b = {b[6:0], sda};
  endtask
  // Acknowledge; a slow part also stretches SCL low
  task automatic ack;
    @(negedge scl) #1 sda_oe = 1'b1;
    scl_oe = slow;
    #(slow ? 300 : 0) scl_oe = 1'b0;
    @(negedge scl) #1 sda_oe = 1'b0;
  endtask
  // Byte leaves MSB first, then the line is let go to its pull-up
  task automatic tx(input logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      #1 sda_oe = !d[i];
      @(negedge scl);
    end
    #1 sda_oe = 1'b0;
    ptr++;
    @(posedge scl) m = sda;
    @(negedge scl);
  endtask
  // Writes only load the word address; reads run on until the reader declines
  always begin : xfer
    wait (armed);
    armed = 1'b0;
    rx;
    if (b[7:1] == ADDR) begin
      ack;
      if (b[0]) begin
        m = 1'b0;
        while (!m) tx(mem[ptr[7:0]]);
      end else begin
        rx;
        ack;
        ptr[15:8] = b;
        rx;
        ack;
        ptr[7:0] = b;
      end
    end
  end
endmodule

// ### test/cid_reader_tb_top.sv
// Self-checking bench: reader against a behavioural identification memory
`timescale 1ns/1ps
`define MEM cid_eeprom_model_i.mem
`define CHK(a, x) begin compares++; if ((a) !== (x)) begin n_errors++; \
  $display("unexpected %0t got %h want %h", $time, a, x); end end
module cid_reader_tb_top;
  import cid_pkg::*;
  logic         clk_sys = 1'b0, clk_link = 1'b0, arst_n = 1'b0, start_req = 1'b0, slow = 1'b0;
  logic [1:0]   board_slot = 2'h0;
  logic [6:0]   pin_sel = 7'h00;
  logic [15:0]  lf = 16'hda84;
  logic         scl_oe, sda_oe, m_scl_oe, m_sda_oe, busy, done, pin_used, edge_rate_select;
  logic         board_present, no_ack, bad_header, format_rev_ok, rx_enable, bias_disable;
  logic         bias_direction_select;
  logic [2:0]   mux_mode;
  logic [15:0]  format_rev, pin_count, cur_board_3v3, cur_board_5v, cur_system_5v;
  logic [15:0]  supplies_board_5v;
  logic [31:0]  hw_version;
  logic [95:0]  serial_number;
  logic [127:0] maker_name, part_number;
  logic [212:0] e, q[$];
  int           n_errors = 0, compares = 0;
  wire          scl = !(scl_oe | m_scl_oe);
  wire          sda = !(sda_oe | m_sda_oe);
  wire [211:0]  act = {board_present, no_ack, bad_header, format_rev_ok, pin_count, cur_board_3v3,
                       cur_board_5v, cur_system_5v, supplies_board_5v, hw_version, serial_number};
  cid_reader #(.QTR(4)) cid_reader_i (.clk_sys, .arst_n, .clk_link, .start_req, .board_slot,
    .pin_sel, .scl_i(scl), .scl_oe, .sda_i(sda), .sda_oe, .busy, .done, .board_present, .no_ack,
    .bad_header, .format_rev_ok, .format_rev, .hw_version, .maker_name, .part_number,
    .pin_count, .serial_number, .cur_board_3v3, .cur_board_5v, .cur_system_5v, .supplies_board_5v,
    .pin_used, .edge_rate_select, .rx_enable, .bias_direction_select, .bias_disable, .mux_mode);
  cid_eeprom_model cid_eeprom_model_i (.scl, .sda, .slow, .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
  initial forever #10 clk_sys = !clk_sys;
  initial begin
    #1.3;
    forever #3 clk_link = !clk_link;
  end
  function automatic logic [7:0] rnd;
    lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction
  function automatic logic [15:0] w(input int a);
    return {`MEM[a], `MEM[a + 1]};
  endfunction
  // Maker and part strings, first byte on top
  function automatic logic [255:0] mp;
    for (int a = 42; a < 74; a++) mp = {mp[247:0], `MEM[a]};
  endfunction
  // Each done pulse settles the oldest note; a spare pulse meets an impossible one
  always @(negedge clk_sys) if (done === 1'b1) begin
    e = q.size() ? q.pop_front() : {5'h0f, 208'h0};
    if (e[212]) `CHK(act, e[211:0])
    else `CHK(act[211:208], e[211:208])
    if (e[212]) `CHK({format_rev, maker_name, part_number}, {w(4), mp()})
  end
  // One image read with a refused second start inside it
  task automatic run(input logic [1:0] s, input logic hb, input logic rv);
    logic ak;
    ak = (s == 2'h2);
    for (int k = 0; k < 256; k++) `MEM[k] = rnd();
    {`MEM[0], `MEM[1], `MEM[2], `MEM[3]} = HDR_MARKER ^ {31'h0, hb};
    {`MEM[4], `MEM[5]} = rv ? REV_A1 : 16'h4132;
    e = {ak, ak && !hb, !ak, ak && hb, ak && rv, w(74), w(236), w(238), w(240), w(242), w(38), w(40)};
    for (int a = 76; a < 88; a += 2) e = {e[196:0], w(a)};
    q.push_back(e);
    @(negedge clk_sys) board_slot = s;
    start_req = 1'b1;
    @(negedge clk_sys) start_req = 1'b0;
    repeat (2) @(negedge clk_sys);
    start_req = 1'b1;
    @(negedge clk_sys) start_req = 1'b0;
    for (int i = 0; i < 60000 && busy !== 1'b0; i++) @(negedge clk_sys);
    if (busy !== 1'b0) n_errors++;
    @(negedge clk_sys);
  endtask
  // Pin lookups: plain, analog and out-of-range indices
  task automatic pins;
    logic [15:0] pw;
    logic [7:0]  got;
    int          pl[7];
    pl = '{0, 5, 66, 67, 73, 74, 0};
    pl[6] = rnd() % 74;
    foreach (pl[i]) begin
      @(negedge clk_sys) pin_sel = pl[i][6:0];
      pw = pl[i] < PIN_COUNT ? w(88 + 2 * pl[i]) : 16'h0000;
      if (pl[i] >= AIN_FIRST) pw = pw & 16'h8000;
      @(negedge clk_sys);
      got = {pin_used, edge_rate_select, rx_enable, bias_direction_select, bias_disable, mux_mode};
      `CHK(got, {pw[15], pw[6:0]})
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Whole run is near 24k system cycles; the 100k-cycle limit, about four times that, means a hang
  initial begin
    #2_000_000;
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    arst_n = 1'b1;
    for (int s = 0; s < 4; s++) run(s[1:0] ^ 2'h1, 1'b0, 1'b1);
    pins;
    slow = 1'b1;
    run(2'h2, 1'b1, 1'b0);
    complete_run;
  end
endmodule
